// [src/ext_align_params.svh]
// constants and rule summary for the external bus data alignment block
// What this block does
// - strap low at reset means big endian
// - big endian puts MSB at lowest address
// - normal memory allows 8, 16, 32 bits
// - DRAM 16 or 32, SDRAM 32 only
// - PC card allows 8 or 16 bits
// - wide accesses split into several bus cycles
// - address steps by bus width per cycle
// - 32-byte burst wraps inside aligned block
// - bus held, no refresh during sequences
// - quadword only from the DMA controller
// - 32-bit BE byte lanes top down
// - 32-bit BE word and longword lanes
// - 32-bit BE quadword high half first
// - 16-bit BE lanes, upper halves first
// - 8-bit BE single lane, MSB first
// - 32-bit LE byte lanes bottom up
`ifndef EXT_ALIGN_PARAMS_SVH
`define EXT_ALIGN_PARAMS_SVH
`define SZ_BYTE 3'h0
`define SZ_WORD 3'h1
`define SZ_LONG 3'h2
`define SZ_QUAD 3'h3
`define SZ_BURST 3'h4
`define DEV_NORMAL 2'h0
`define DEV_DRAM 2'h1
`define DEV_SDRAM 2'h2
`define DEV_PCARD 2'h3
`define W8 2'h0
`define W16 2'h1
`define W32 2'h2
`define BLK_MASK 5'h1f
`endif

// [src/ext_align_pkg.sv]
// types for the external bus data alignment block
package ext_align_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] size;
    logic [1:0] dev;
    logic [1:0] width;
    logic from_dma;
    logic write;
    logic [63:0] wdata;
  } req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strobe;
    logic write;
  } bus_t;
endpackage

// [src/ext_align.sv]
// splits internal accesses into aligned external bus cycles
`timescale 1ns/10ps
`include "ext_align_params.svh"
module ext_align #(
  parameter int BURST_BYTES = 32
) (
  // clock, reset and endian strap
  input wire logic clk,
  input wire logic srst,
  input wire logic endian_strap_pin,
  // internal request
  input wire logic req_valid,
  input wire ext_align_pkg::req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [63:0] rsp_data,
  // external bus
  output logic bus_valid,
  output ext_align_pkg::bus_t bus,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  output logic bus_hold,
  output logic refresh_allow,
  output logic little_endian
);
  initial begin
    if (BURST_BYTES != 32) $error("burst length must be 32");
  end

  ext_align_pkg::state_t st_r, st_nxt;
  ext_align_pkg::req_t q_r, q_nxt;
  logic [5:0] off_r, off_nxt;      // bytes moved so far
  logic [63:0] acc_r, acc_nxt;
  logic le_r, le_nxt, strap_done_r, strap_done_nxt;
  logic bv_r, bv_nxt, rv_r, rv_nxt, re_r, re_nxt;
  ext_align_pkg::bus_t b_r, b_nxt;

  logic [5:0] total;
  logic [2:0] bw;
  logic [2:0] wbytes;
  logic [1:0] lane;
  logic [5:0] eoff;
  logic [5:0] roff;
  logic [3:0] strb;
  logic [31:0] cyc_addr, ldata;
  logic legal;

  function automatic logic [5:0] size_bytes(input logic [2:0] s);
    case (s)
      `SZ_BYTE: size_bytes = 6'h01;
      `SZ_WORD: size_bytes = 6'h02;
      `SZ_LONG: size_bytes = 6'h04;
      `SZ_QUAD: size_bytes = 6'h08;
      default: size_bytes = 6'h20;
    endcase
  endfunction

  always_comb begin
    total = size_bytes(q_r.size);
    unique case (q_r.width)
      `W8: bw = 3'h1;
      `W16: bw = 3'h2;
      default: bw = 3'h4;
    endcase
    wbytes = bw;
    // bytes this cycle: min of bus width and whole access size
    if ({3'h0, bw} > total) bw = total[2:0];
    // burst wraps inside the aligned 32-byte block
    if (q_r.size == `SZ_BURST) begin
      cyc_addr = {q_r.addr[31:5], 5'(q_r.addr[4:0] + off_r[4:0])};
    end else begin
      cyc_addr = q_r.addr + 32'(off_r);
    end
    lane = cyc_addr[1:0];
    if (q_r.width == `W16) lane = {1'b0, cyc_addr[0]};
    if (q_r.width == `W8) lane = 2'h0;
    if (bw == 3'h4) lane = 2'h0;
    if (bw == 3'h2 && q_r.width == `W32) lane = {cyc_addr[1], 1'b0};
    // big endian mirrors the base lane inside the bus width
    if (!le_r) lane = 2'(wbytes - bw) - lane;
    strb = 4'h0;
    ldata = 32'h0;
    eoff = 6'h0;
    for (int i = 0; i < 4; i++) begin
      // eoff = byte offset of this lane's byte within access value
      if (i < bw) begin
        if (le_r) begin
          eoff = off_r + 6'(i);
        end else begin
          eoff = total - 6'h1 - off_r - 6'(bw - 3'h1) + 6'(i);
        end
        if (q_r.size == `SZ_BURST) eoff = 6'h0;
        strb[lane + 2'(i)] = 1'b1;
        ldata[8*(lane+2'(i)) +: 8] = q_r.wdata[8*eoff[2:0] +: 8];
      end else begin
        eoff = 6'h0;
      end
    end
    unique case (req.dev)
      `DEV_NORMAL: legal = req.width != 2'h3;
      `DEV_DRAM: legal = req.width != `W8 && req.width != 2'h3;
      `DEV_SDRAM: legal = req.width == `W32;
      default: legal = req.width != `W32 && req.width != 2'h3;
    endcase
    if (req.size == `SZ_QUAD && !req.from_dma) legal = 1'b0;
    if (req.size > `SZ_BURST) legal = 1'b0;
  end

  always_comb begin
    st_nxt = st_r;
    q_nxt = q_r;
    off_nxt = off_r;
    acc_nxt = acc_r;
    le_nxt = le_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r) le_nxt = endian_strap_pin;
    bv_nxt = bv_r;
    b_nxt = b_r;
    roff = 6'h0;
    rv_nxt = 1'b0;
    re_nxt = 1'b0;
    unique case (st_r)
      ext_align_pkg::ST_IDLE: begin
        if (req_valid && strap_done_r) begin
          if (legal) begin
            q_nxt = req;
            off_nxt = 6'h0;
            acc_nxt = 64'h0;
            st_nxt = ext_align_pkg::ST_RUN;
          end else begin
            rv_nxt = 1'b1;
            re_nxt = 1'b1;
          end
        end
      end
      ext_align_pkg::ST_RUN: begin
        if (!bv_r) begin
          bv_nxt = 1'b1;
          b_nxt = '{addr: cyc_addr, data: ldata, strobe: strb,
                    write: q_r.write};
        end else if (bus_ack) begin
          bv_nxt = 1'b0;
          // collect only strobed lanes into the access value
          for (int i = 0; i < 4; i++) begin
            if (i < bw && q_r.size != `SZ_BURST) begin
              if (le_r) roff = off_r + 6'(i);
              else roff = total - 6'h1 - off_r - 6'(bw - 3'h1) + 6'(i);
              acc_nxt[8*roff[2:0] +: 8] =
                bus_rdata[8*(lane+2'(i)) +: 8];
            end
          end
          off_nxt = off_r + 6'(bw);
          if (off_r + 6'(bw) >= total) st_nxt = ext_align_pkg::ST_DONE;
        end
      end
      ext_align_pkg::ST_DONE: begin
        rv_nxt = 1'b1;
        st_nxt = ext_align_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ext_align_pkg::ST_IDLE;
      q_r <= '0;
      off_r <= 6'h0;
      acc_r <= 64'h0;
      le_r <= 1'b0;
      strap_done_r <= 1'b0;
      bv_r <= 1'b0;
      b_r <= '0;
      rv_r <= 1'b0;
      re_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      off_r <= off_nxt;
      acc_r <= acc_nxt;
      le_r <= le_nxt;
      strap_done_r <= strap_done_nxt;
      bv_r <= bv_nxt;
      b_r <= b_nxt;
      rv_r <= rv_nxt;
      re_r <= re_nxt;
    end
  end

  logic hold_r, ready_r, allow_r;
  // ready and refresh permission registered so outputs leave flops
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_r <= 1'b0;
      ready_r <= 1'b0;
      allow_r <= 1'b1;
    end else begin
      hold_r <= st_nxt != ext_align_pkg::ST_IDLE;
      ready_r <= st_nxt == ext_align_pkg::ST_IDLE;
      allow_r <= st_nxt == ext_align_pkg::ST_IDLE;
    end
  end

  assign req_ready = ready_r;
  assign rsp_valid = rv_r;
  assign rsp_error = re_r;
  assign rsp_data = acc_r;
  assign bus_valid = bv_r;
  assign bus = b_r;
  assign bus_hold = hold_r;
  assign refresh_allow = allow_r;
  assign little_endian = le_r;

  no_refresh_a: assert property (@(posedge clk) disable iff (srst)
    bus_valid |-> !refresh_allow) else $error("refresh during seq");
  quad_dma_a: assert property (@(posedge clk) disable iff (srst)
    (bus_valid && q_r.size == `SZ_QUAD) |-> q_r.from_dma)
    else $error("quad not from dma");
  full_strobe_a: assert property (@(posedge clk) disable iff (srst)
    (bus_valid && q_r.width == `W32 && q_r.size >= `SZ_LONG)
    |-> bus.strobe == 4'hf) else $error("strobes not all set");
  lane8_a: assert property (@(posedge clk) disable iff (srst)
    (bus_valid && q_r.width == `W8) |-> bus.strobe == 4'h1)
    else $error("8-bit lane wrong");
  lane16_a: assert property (@(posedge clk) disable iff (srst)
    (bus_valid && q_r.width == `W16) |-> bus.strobe[3:2] == 2'h0)
    else $error("16-bit lane wrong");
  be_byte_a: assert property (@(posedge clk) disable iff (srst)
    (bus_valid && !le_r && q_r.width == `W32 && q_r.size == `SZ_BYTE)
    |-> bus.strobe == 4'(4'h8 >> bus.addr[1:0]))
    else $error("be byte lane wrong");
  le_byte_a: assert property (@(posedge clk) disable iff (srst)
    (bus_valid && le_r && q_r.width == `W32 && q_r.size == `SZ_BYTE)
    |-> bus.strobe == 4'(4'h1 << bus.addr[1:0]))
    else $error("le byte lane wrong");
  // ack of a non-final byte cycle, idle gap, next cycle presented
  sequence long8_gap_s;
    (bus_valid && bus_ack && q_r.size == `SZ_LONG && q_r.width == `W8
    && st_nxt == ext_align_pkg::ST_RUN) ##1 !bus_valid ##1 bus_valid;
  endsequence
  step_a: assert property (@(posedge clk) disable iff (srst)
    long8_gap_s |-> bus.addr == $past(bus.addr, 2) + 32'h1)
    else $error("address step wrong");
  wrap_a: assert property (@(posedge clk) disable iff (srst)
    bus_valid && q_r.size == `SZ_BURST
    |-> bus.addr[31:5] == q_r.addr[31:5]) else $error("burst wrap");
endmodule

// [tb/ext_mem_model.sv]
// partner memory answering external bus cycles after a random wait
`timescale 1ns/10ps
module ext_mem_model (
  // clock
  input wire logic clk,
  // external bus
  input wire logic bus_valid,
  input wire ext_align_pkg::bus_t bus,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  logic [7:0] mem [logic [33:0]];
  int wait_r = 0;
  logic ack_r = 1'b0;
  logic [31:0] rd_r = 32'h0;
  assign bus_ack = ack_r;
  assign bus_rdata = rd_r;
  always @(posedge clk) begin
    ack_r <= 1'b0;
    // lanes toggle outside the ack cycle so stale data is never reused
    rd_r <= ~rd_r;
    if (bus_valid && !ack_r) begin
      if (wait_r == 0) begin
        ack_r <= 1'b1;
        wait_r = $urandom % 3;
        for (int i = 0; i < 4; i++) begin
          if (bus.write && bus.strobe[i])
            mem[{bus.addr, 2'(i)}] = bus.data[8*i +: 8];
          rd_r[8*i +: 8] <= mem.exists({bus.addr, 2'(i)}) ?
            mem[{bus.addr, 2'(i)}] : 8'h5a;
        end
      end else begin
        wait_r--;
      end
    end
  end
endmodule

// [tb/external_bus_data_alignment_bench.sv]
// self-checking bench for the external bus alignment block
`timescale 1ns/10ps
module external_bus_data_alignment_bench;
  logic clk = 1'b0, srst = 1'b1, strap = 1'b0, req_valid = 1'b0, le;
  ext_align_pkg::req_t req = '0;
  ext_align_pkg::req_t cur;
  ext_align_pkg::bus_t bus;
  logic req_ready, rsp_valid, rsp_error, bus_valid, bus_ack;
  logic bus_hold, refresh_allow, little_endian;
  logic [63:0] rsp_data;
  logic [31:0] bus_rdata, ln;
  int bad_count = 0, compares = 0, cyc = 0;
  always #5 clk = ~clk;
  ext_align i_dut (.clk(clk), .srst(srst), .endian_strap_pin(strap),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data),
    .bus_valid(bus_valid), .bus(bus), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .bus_hold(bus_hold),
    .refresh_allow(refresh_allow), .little_endian(little_endian));
  ext_mem_model i_mem (.clk(clk), .bus_valid(bus_valid), .bus(bus),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  task automatic check(logic [63:0] got, logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic int nb(ext_align_pkg::req_t r);
    return r.size == 3'h4 ? 32 : 1 << r.size;
  endfunction
  function automatic int wb(ext_align_pkg::req_t r);
    return 1 << r.width;
  endfunction
  function automatic int sh(ext_align_pkg::req_t r);
    return le ? r.addr % wb(r) : wb(r) - nb(r) - r.addr % wb(r);
  endfunction
  function automatic logic [3:0] e_strb(ext_align_pkg::req_t r);
    if (nb(r) >= wb(r)) return 4'((1 << wb(r)) - 1);
    return 4'(((1 << nb(r)) - 1) << sh(r));
  endfunction
  function automatic logic [31:0] e_data(ext_align_pkg::req_t r, int k);
    if (nb(r) < wb(r)) return r.wdata[31:0] << (8 * sh(r));
    return 32'(r.wdata >> (8 * wb(r) * (le ? k : nb(r) / wb(r) - 1 - k)));
  endfunction
  function automatic logic [31:0] e_addr(ext_align_pkg::req_t r, int k);
    if (r.size == 3'h4) return {r.addr[31:5], 5'(r.addr[4:0] + k * wb(r))};
    return r.addr + 32'(k * wb(r));
  endfunction
  // sampled mid-cycle, where bus outputs and ack have settled
  always @(negedge clk) begin
    if (bus_valid) begin
      check(bus_hold && !refresh_allow, 1);
      if (bus_ack) begin
        ln = {{8{bus.strobe[3]}}, {8{bus.strobe[2]}},
          {8{bus.strobe[1]}}, {8{bus.strobe[0]}}};
        check(bus.addr, e_addr(cur, cyc));
        check(bus.write, cur.write);
        check(bus.strobe, e_strb(cur));
        if (cur.write && cur.size != 3'h4)
          check(bus.data & ln, e_data(cur, cyc) & ln);
        cyc++;
      end
    end
  end
  task automatic op(ext_align_pkg::req_t r, logic bad);
    int t = 0;
    while (!req_ready && t++ < 100) @(negedge clk);
    check(req_ready, 1'b1);
    cur = r;
    cyc = 0;
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    t = 0;
    do @(negedge clk); while (!rsp_valid && t++ < 400);
    check(rsp_valid, 1'b1);
    check(rsp_error, bad);
    check(cyc, bad ? 0 : (nb(r) < wb(r) ? 1 : nb(r) / wb(r)));
    if (!bad && !r.write && r.size != 3'h4)
      check(rsp_data, r.wdata & ~(64'hffffffffffffffff << (8 * nb(r))));
  endtask
  task automatic go(int s, int d, int w, logic m, logic [31:0] a);
    ext_align_pkg::req_t r;
    logic bad;
    r = '{addr: a, size: 3'(s), dev: 2'(d), width: 2'(w), from_dma: m,
      write: 1'b1, wdata: {$urandom, $urandom}};
    bad = (d == 1 && w == 0) || (d == 2 && w != 2) || (d == 3 && w == 2) ||
      (s == 3 && !m);
    op(r, bad);
    r.write = 1'b0;
    op(r, bad);
  endtask
  initial begin
    void'($urandom(32'h716c));
    for (int p = 0; p < 2; p++) begin
      le = p[0];
      @(posedge clk);
      strap <= p[0];
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      check(little_endian, le);
      for (int w = 0; w < 3; w++) begin
        for (int a = 0; a < 4; a++) go(0, 0, w, 1'b1, 32'h40 + a);
        go(4, 0, w, 1'b0, 32'h114);
      end
      repeat (60) begin
        int s, w;
        s = $urandom % 4;
        w = $urandom % 3;
        // sizes stay aligned; misaligned splits are not defined
        go(s, $urandom % 4, w, $urandom % 2,
          32'($urandom % 4096) & ~32'((1 << s) - 1));
      end
    end
    finish_test;
  end
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
endmodule
